// *** bench/dcpwm_fb_model.sv ***
// fieldbus slave model feeding process data and state to the pwm block
`timescale 1ns/1ps
module dcpwm_fb_model (
    // clock
    input  wire logic        mclk,
    // commands from the bench
    input  wire logic        run_pd,
    input  wire logic [3:0]  st_cmd,
    input  wire logic [15:0] d1,
    input  wire logic [15:0] d2,
    // process data towards the block
    output logic [15:0]      duty_ch1,
    output logic [15:0]      duty_ch2,
    output logic             pd_valid,
    output logic [3:0]       bus_state
);
    logic [3:0] gap = 4'h0;
    initial begin
        duty_ch1 = 16'h0000;
        duty_ch2 = 16'h0000;
        pd_valid = 1'b0;
        bus_state = 4'h1;
    end
    // one exchange every 16 cycles, well inside the shortened watchdog
    always @(posedge mclk) begin
        gap <= gap + 4'h1;
        pd_valid <= run_pd && (gap == 4'hf);
        duty_ch1 <= d1;
        duty_ch2 <= d2;
        bus_state <= st_cmd;
    end
endmodule // dcpwm_fb_model

// *** bench/test_dcpwm_top.sv ***
// self-checking bench for the dual-channel pwm output block
`timescale 1ns/1ps
module test_dcpwm_top;
    typedef struct {logic [15:0] a; logic [15:0] b; int ea; int eb; int tol;} dcpwm_row_t;
    logic mclk = 0, rstn = 0, freq_set = 0, wdog_en = 0, run_pd = 0;
    logic [3:0] st_cmd = 4'h1;
    logic [15:0] d1 = 16'h0000, d2 = 16'h0000;
    logic [14:0] freq_hz = 15'h0000;
    logic [15:0] duty_ch1, duty_ch2;
    logic [3:0] bus_state;
    logic pd_valid, pwm_ch1, pwm_ch2, ch1_indicator, ch2_indicator, run_indicator, wdog_tripped;
    int failures = 0, check_count = 0, h1, h2, hr, bad = 0;
    // back-to-back duty changes; 5000-cycle period at 20 kHz
    dcpwm_row_t rows[3] = '{'{16'h8000, 16'h4000, 2500, 1250, 2},
                           '{16'hffff, 16'h0000, 5000, 0, 0},
                           '{16'h0000, 16'hc000, 0, 3750, 2}};
    always #5 mclk = ~mclk;
    dcpwm_fb_model dcpwm_fb_model_i (.mclk(mclk), .run_pd(run_pd), .st_cmd(st_cmd), .d1(d1), .d2(d2),
        .duty_ch1(duty_ch1), .duty_ch2(duty_ch2), .pd_valid(pd_valid), .bus_state(bus_state));
    // short counts keep watchdog and flash timing inside the run
    dcpwm_top #(.WDOG_CYC(50), .FL_ON(3), .FL_PER(10), .BLINK(4)) dcpwm_top_i (.mclk(mclk), .rstn(rstn),
        .duty_ch1(duty_ch1), .duty_ch2(duty_ch2), .pd_valid(pd_valid), .bus_state(bus_state),
        .freq_hz(freq_hz), .freq_set(freq_set), .wdog_en(wdog_en), .pwm_ch1(pwm_ch1), .pwm_ch2(pwm_ch2),
        .ch1_indicator(ch1_indicator), .ch2_indicator(ch2_indicator), .run_indicator(run_indicator),
        .wdog_tripped(wdog_tripped));
    // indicators must track outputs on every cycle
    always @(posedge mclk) begin
        if (rstn && (ch1_indicator !== pwm_ch1 || ch2_indicator !== pwm_ch2)) bad++;
    end
    task automatic tally_and_finish;
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
        check_count++;
        if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // high-cycle counts over a window
    task automatic measure(input int n);
        h1 = 0;
        h2 = 0;
        hr = 0;
        repeat (n) begin
            @(posedge mclk);
            h1 += (pwm_ch1 === 1'b1);
            h2 += (pwm_ch2 === 1'b1);
            hr += (run_indicator === 1'b1);
        end
    endtask
    task automatic set_freq(input logic [14:0] f);
        @(posedge mclk) begin
            freq_hz <= f;
            freq_set <= 1'b1;
        end
        @(posedge mclk) freq_set <= 1'b0;
    endtask
    initial begin
        measure(10);
        chk(h1 + h2 + hr + (wdog_tripped !== 1'b0), 0, 0);
        @(posedge mclk) rstn <= 1'b1;
        measure(20);
        chk(hr, 0, 0);
        set_freq(15'h4e20);
        @(posedge mclk) begin
            st_cmd <= 4'h8;
            run_pd <= 1'b1;
        end
        // new duty is applied from a period start, so skip a full period first
        foreach (rows[i]) begin
            @(posedge mclk) begin
                d1 <= rows[i].a;
                d2 <= rows[i].b;
            end
            settle(5100);
            measure(5000);
            chk(h1, rows[i].ea, rows[i].tol);
            chk(h2, rows[i].eb, rows[i].tol);
            chk(hr, 5000, 0);
        end
        // out-of-range frequency must leave the period alone
        @(posedge mclk) d1 <= 16'h8000;
        set_freq(15'h7fff);
        settle(5100);
        measure(5000);
        chk(h1, 2500, 2);
        set_freq(15'h2710);
        settle(10100);
        measure(10000);
        chk(h1, 5000, 2);
        // safe-op: outputs low, duty 0 offered but refused
        @(posedge mclk) begin
            st_cmd <= 4'h4;
            d1 <= 16'h0000;
        end
        settle(40);
        measure(10);
        chk(h1, 0, 0);
        chk(hr, 3, 0);
        // preop blinks, bootstrap run indicator is not checked; outputs held low in both
        @(posedge mclk) st_cmd <= 4'h2;
        settle(20);
        measure(16);
        chk(h1 + h2, 0, 0);
        chk(hr, 8, 0);
        @(posedge mclk) st_cmd <= 4'h3;
        settle(20);
        measure(16);
        chk(h1 + h2, 0, 0);
        @(posedge mclk) begin
            run_pd <= 1'b0;
            st_cmd <= 4'h8;
        end
        settle(10100);
        measure(10000);
        chk(h1, 5000, 2);
        // watchdog trips with no exchanges; state stays operational
        @(posedge mclk) wdog_en <= 1'b1;
        settle(60);
        chk(wdog_tripped, 1, 0);
        measure(200);
        chk(h1 + h2, 0, 0);
        chk(hr, 200, 0);
        @(posedge mclk) run_pd <= 1'b1;
        settle(30);
        chk(wdog_tripped, 0, 0);
        // mid-run reset: all dark while held; op lights run again, duty waits for a period start
        @(posedge mclk) rstn <= 1'b0;
        settle(2);
        measure(3);
        chk(h1 + h2 + hr + (wdog_tripped !== 1'b0), 0, 0);
        @(posedge mclk) rstn <= 1'b1;
        measure(20);
        chk(hr, 19, 0);
        chk(h1 + h2, 0, 0);
        chk(bad, 0, 0);
        tally_and_finish();
    end
    // hang guard, beyond the roughly 0.81 ms of tests but under 100k cycles
    initial begin
        #950_000;
        failures++;
        tally_and_finish();
    end
endmodule // test_dcpwm_top

// *** design/dcpwm_channel.sv ***
// one pwm channel: phase compare, shadowed duty and output flop
`timescale 1ns/1ps
module dcpwm_channel #(
    parameter int DUTY_W = 16
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // timing
    input  wire logic              period_start,
    input  wire logic [DUTY_W-1:0] phase,
    // control
    input  wire logic [DUTY_W-1:0] duty,
    input  wire logic              force_low,
    // output
    output logic                   pwm_out
);
    logic [DUTY_W-1:0] duty_reg;
    logic [DUTY_W-1:0] duty_next;
    logic              out_reg;
    logic              out_next;
    localparam logic [DUTY_W-1:0] DUTY_MAX = '1;

    // duty latched only at period start so no runt pulse appears
    always_comb begin
        duty_next = period_start ? duty : duty_reg;
        if (force_low) begin
            out_next = 1'b0;
        end else if (duty_next == DUTY_MAX) begin
            out_next = 1'b1;
        end else begin
            out_next = (phase < duty_next);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            duty_reg <= '0;
            out_reg  <= 1'b0;
        end else begin
            duty_reg <= duty_next;
            out_reg  <= out_next;
        end
    end

    assign pwm_out = out_reg;
endmodule // dcpwm_channel

// *** design/dcpwm_top.sv ***
// dual-channel pwm output with fieldbus state handling, watchdog and indicators
`timescale 1ns/1ps
module dcpwm_top #(
    parameter int DUTY_W   = dcpwm_pkg::DUTY_W,
    parameter int NCH      = 2,
    parameter int WDOG_CYC = dcpwm_pkg::WDOG_CYC,
    parameter int FL_ON    = dcpwm_pkg::FLASH_ON_CYC,
    parameter int FL_PER   = dcpwm_pkg::FLASH_PER_CYC,
    parameter int BLINK    = dcpwm_pkg::BLINK_CYC
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // process data from fieldbus side
    input  wire logic [DUTY_W-1:0] duty_ch1,
    input  wire logic [DUTY_W-1:0] duty_ch2,
    input  wire logic              pd_valid,
    input  wire logic [3:0]        bus_state,
    // configuration
    input  wire logic [14:0]       freq_hz,
    input  wire logic              freq_set,
    input  wire logic              wdog_en,
    // outputs and indicators
    output logic                   pwm_ch1,
    output logic                   pwm_ch2,
    output logic                   ch1_indicator,
    output logic                   ch2_indicator,
    output logic                   run_indicator,
    output logic                   wdog_tripped
);
    // refuse parameter sets that the fixed two-channel, 16-bit datapath cannot serve
    if (DUTY_W != 16 || NCH != 2 || WDOG_CYC < 1 || FL_ON < 1 || FL_PER <= FL_ON || BLINK < 1) begin : g_bad_param
        $error("dcpwm_top: unsupported parameters");
    end

    localparam logic [31:0] PER_RST = 32'(dcpwm_pkg::CLK_HZ / dcpwm_pkg::FREQ_RST_HZ);

    // base period length in clocks and phase accumulator
    logic [31:0] per_reg, per_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [DUTY_W-1:0] phase;
    logic        start;
    logic [47:0] prod;

    always_comb begin
        per_next = per_reg;
        if (freq_set && freq_hz >= 15'(dcpwm_pkg::FREQ_MIN_HZ) && freq_hz <= 15'(dcpwm_pkg::FREQ_MAX_HZ)) begin
            per_next = 32'(dcpwm_pkg::CLK_HZ) / {17'd0, freq_hz};
        end
        start    = (cnt_reg >= per_reg - 32'd1);
        cnt_next = start ? 32'd0 : cnt_reg + 32'd1;
    end
    // phase scaled to 16 bits so duty maps linearly onto the period
    assign prod  = {16'd0, cnt_reg} << DUTY_W;
    assign phase = DUTY_W'(prod / {16'd0, per_reg});

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            per_reg <= PER_RST;
            cnt_reg <= '0;
        end else begin
            per_reg <= per_next;
            cnt_reg <= cnt_next;
        end
    end

    // duty capture: accepted only while operational
    logic [DUTY_W-1:0] d1_reg, d1_next, d2_reg, d2_next;
    logic [31:0]       wd_reg, wd_next;
    logic              trip_reg, trip_next;
    wire               is_op = (bus_state == dcpwm_pkg::ST_OP);

    always_comb begin
        d1_next = d1_reg;
        d2_next = d2_reg;
        if (is_op && pd_valid) begin
            d1_next = duty_ch1;
            d2_next = duty_ch2;
        end
        // watchdog restarts on valid data; trip does not alter bus state
        if (pd_valid || !wdog_en) begin
            wd_next   = '0;
            trip_next = 1'b0;
        end else if (wd_reg >= 32'(WDOG_CYC - 1)) begin
            wd_next   = wd_reg;
            trip_next = 1'b1;
        end else begin
            wd_next   = wd_reg + 32'd1;
            trip_next = trip_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            d1_reg   <= '0;
            d2_reg   <= '0;
            wd_reg   <= '0;
            trip_reg <= 1'b0;
        end else begin
            d1_reg   <= d1_next;
            d2_reg   <= d2_next;
            wd_reg   <= wd_next;
            trip_reg <= trip_next;
        end
    end

    // outputs forced low outside operational or on watchdog trip
    logic force_low;
    logic [NCH-1:0] pwm_w;
    logic [DUTY_W-1:0] duty_arr [NCH];
    assign force_low   = !is_op || trip_reg;
    assign duty_arr[0] = d1_reg;
    assign duty_arr[1] = d2_reg;

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            dcpwm_channel #(.DUTY_W(DUTY_W)) u_ch (
                .mclk         (mclk),
                .rstn         (rstn),
                .period_start (start),
                .phase        (phase),
                .duty         (duty_arr[gi]),
                .force_low    (force_low),
                .pwm_out      (pwm_w[gi])
            );
        end
    endgenerate

    // output and indicator flops; indicators copy the same next value
    logic [NCH-1:0] out_reg;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            out_reg <= '0;
        end else begin
            out_reg <= pwm_w;
        end
    end
    assign pwm_ch1       = out_reg[0];
    assign pwm_ch2       = out_reg[1];
    assign ch1_indicator = out_reg[0];
    assign ch2_indicator = out_reg[1];
    assign wdog_tripped  = trip_reg;

    // run indicator pattern generator
    logic [31:0] fl_reg, fl_next;
    logic [31:0] bk_reg, bk_next;
    logic        blk_reg, blk_next;
    logic        run_reg, run_next;
    always_comb begin
        fl_next  = (fl_reg >= 32'(FL_PER - 1)) ? 32'd0 : fl_reg + 32'd1;
        bk_next  = (bk_reg >= 32'(BLINK - 1)) ? 32'd0 : bk_reg + 32'd1;
        blk_next = (bk_reg >= 32'(BLINK - 1)) ? !blk_reg : blk_reg;
        case (bus_state)
            dcpwm_pkg::ST_INIT:   run_next = 1'b0;
            dcpwm_pkg::ST_PREOP:  run_next = blk_reg;
            dcpwm_pkg::ST_SAFEOP: run_next = (fl_reg < 32'(FL_ON));
            dcpwm_pkg::ST_OP:     run_next = 1'b1;
            dcpwm_pkg::ST_BOOT:   run_next = bk_reg[22];
            default:              run_next = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fl_reg  <= '0;
            bk_reg  <= '0;
            blk_reg <= 1'b0;
            run_reg <= 1'b0;
        end else begin
            fl_reg  <= fl_next;
            bk_reg  <= bk_next;
            blk_reg <= blk_next;
            run_reg <= run_next;
        end
    end
    assign run_indicator = run_reg;

    // checks; duty checks watch the channel shadow, because a fresh capture
    // only reaches the pin at the next period start

    // state-driven outputs and run indicator
    leds_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
        ch1_indicator == pwm_ch1 && ch2_indicator == pwm_ch2) else $error("indicator mismatch");
    init_dark_a: assert property (@(posedge mclk) disable iff (!rstn)
        bus_state == dcpwm_pkg::ST_INIT |=> !run_indicator) else $error("run lit in init");
    safe_low_a: assert property (@(posedge mclk) disable iff (!rstn)
        (bus_state != dcpwm_pkg::ST_OP)[*2] |=> !pwm_ch1 && !pwm_ch2) else $error("output high outside op");
    safe_flash_a: assert property (@(posedge mclk) disable iff (!rstn)
        bus_state == dcpwm_pkg::ST_SAFEOP && fl_reg < 32'(FL_ON) |=> run_indicator) else $error("flash not lit");
    safe_dark_a: assert property (@(posedge mclk) disable iff (!rstn)
        bus_state == dcpwm_pkg::ST_SAFEOP && fl_reg >= 32'(FL_ON) |=> !run_indicator) else $error("flash too long");
    op_run_a: assert property (@(posedge mclk) disable iff (!rstn)
        bus_state == dcpwm_pkg::ST_OP |=> run_indicator) else $error("run not lit in op");
    op_capture_a: assert property (@(posedge mclk) disable iff (!rstn)
        !is_op |=> $stable(d1_reg)) else $error("duty taken outside op");
    // watchdog
    wdog_trip_a: assert property (@(posedge mclk) disable iff (!rstn)
        trip_reg |=> ##1 (!pwm_ch1 && !pwm_ch2)) else $error("outputs high after trip");
    wdog_time_a: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(trip_reg) |-> wd_reg == 32'(WDOG_CYC - 1)) else $error("watchdog early");
    wdog_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        pd_valid |=> !trip_reg) else $error("trip kept after exchange");
    // duty mapping, both channels on their own shadow; shadow hold checked on channel 0 only
    zero_low_a: assert property (@(posedge mclk) disable iff (!rstn)
        (is_op && !trip_reg && g_ch[0].u_ch.duty_reg == '0)[*3] |=> !pwm_ch1) else $error("zero duty not low");
    full_high_a: assert property (@(posedge mclk) disable iff (!rstn)
        (is_op && !trip_reg && g_ch[0].u_ch.duty_reg == '1)[*3] |=> pwm_ch1) else $error("full duty not high");
    zero_low_two_a: assert property (@(posedge mclk) disable iff (!rstn)
        (is_op && !trip_reg && g_ch[1].u_ch.duty_reg == '0)[*3] |=> !pwm_ch2) else $error("zero duty not low");
    full_high_two_a: assert property (@(posedge mclk) disable iff (!rstn)
        (is_op && !trip_reg && g_ch[1].u_ch.duty_reg == '1)[*3] |=> pwm_ch2) else $error("full duty not high");
    shadow_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !start |=> $stable(g_ch[0].u_ch.duty_reg)) else $error("duty changed mid period");
    // period length and frequency loading
    reset_freq_a: assert property (@(posedge mclk)
        !rstn |=> per_reg == PER_RST) else $error("reset period wrong");
    freq_load_a: assert property (@(posedge mclk) disable iff (!rstn)
        freq_set && freq_hz >= 15'(dcpwm_pkg::FREQ_MIN_HZ) && freq_hz <= 15'(dcpwm_pkg::FREQ_MAX_HZ)
        |=> per_reg == 32'(dcpwm_pkg::CLK_HZ) / {17'd0, $past(freq_hz)}) else $error("period not loaded");
    freq_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
        freq_set && freq_hz > 15'(dcpwm_pkg::FREQ_MAX_HZ) |=> $stable(per_reg)) else $error("bad frequency taken");
endmodule // dcpwm_top

// *** inc/dcpwm_pkg.sv ***
// package with constants and state codes for the dual-channel pwm output block
package dcpwm_pkg;
    localparam int CLK_HZ          = 100_000_000;
    localparam int DUTY_W          = 16;
    localparam int FREQ_MIN_HZ     = 1;
    localparam int FREQ_MAX_HZ     = 20_000;
    localparam int FREQ_RST_HZ     = 250;
    localparam int WDOG_MS         = 100;
    localparam int WDOG_CYC        = CLK_HZ / 1000 * WDOG_MS;
    // run indicator blink timing
    localparam int FLASH_ON_MS     = 200;
    localparam int FLASH_PERIOD_MS = 1200;
    localparam int BLINK_MS        = 200;
    localparam int FLASH_ON_CYC    = CLK_HZ / 1000 * FLASH_ON_MS;
    localparam int FLASH_PER_CYC   = CLK_HZ / 1000 * FLASH_PERIOD_MS;
    localparam int BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;
    // fieldbus state codes
    localparam logic [3:0] ST_INIT   = 4'h1;
    localparam logic [3:0] ST_PREOP  = 4'h2;
    localparam logic [3:0] ST_BOOT   = 4'h3;
    localparam logic [3:0] ST_SAFEOP = 4'h4;
    localparam logic [3:0] ST_OP     = 4'h8;
endpackage
